// File: inc/evo_pkg.sv
// Shared constants, codes and carrier types of the event output action unit
`default_nettype none
package evo_pkg;
   localparam int NUM_OUT = 16;
   localparam int NUM_EV  = 3;
   localparam int ADDR_W  = 10;
   localparam int DATA_W  = 32;
   // Action mode codes
   localparam logic [4:0] MODE_NONE     = 5'h01;
   localparam logic [4:0] MODE_HIGH_DEVIATION_ALARM   = 5'h02;
   localparam logic [4:0] MODE_DEV_LO   = 5'h03;
   localparam logic [4:0] MODE_OUTSIDE_BAND_ALARM  = 5'h04;
   localparam logic [4:0] MODE_INSIDE_BAND_ALARM   = 5'h05;
   localparam logic [4:0] MODE_MEASURED_HIGH_ABSOLUTE    = 5'h06;
   localparam logic [4:0] MODE_PV_LO    = 5'h07;
   localparam logic [4:0] MODE_SCALE    = 5'h08;
   localparam logic [4:0] MODE_FIX      = 5'h09;
   localparam logic [4:0] MODE_TUNE     = 5'h0a;
   localparam logic [4:0] MODE_MANUAL   = 5'h0b;
   localparam logic [4:0] MODE_LOGIC    = 5'h0c;
   localparam logic [4:0] MODE_RUN      = 5'h0d;
   localparam logic [4:0] MODE_HOLD     = 5'h0e;
   localparam logic [4:0] MODE_SOAK     = 5'h0f;
   localparam logic [4:0] MODE_STEP     = 5'h10;
   localparam logic [4:0] MODE_END      = 5'h11;
   localparam logic [4:0] MODE_TS_FIRST = 5'h12;
   localparam logic [4:0] MODE_TS_LAST  = 5'h19;
   localparam logic [4:0] MODE_HEAT_BRK = 5'h1a;
   localparam logic [4:0] MODE_HEAT_LP  = 5'h1b;
   localparam logic [4:0] MODE_POS_HI   = 5'h1a;
   localparam logic [4:0] MODE_POS_LO   = 5'h1b;
   localparam logic [4:0] MODE_POT_ERR  = 5'h1c;
   // Inhibit settings
   localparam logic [1:0] IH_OFF   = 2'h0;
   localparam logic [1:0] IH_POWER = 2'h1;
   localparam logic [1:0] IH_SV    = 2'h2;
   localparam logic [1:0] IH_NONE  = 2'h3;
   // Comparator kinds
   localparam logic [1:0] KIND_HI  = 2'h0;
   localparam logic [1:0] KIND_LO  = 2'h1;
   localparam logic [1:0] KIND_OUT = 2'h2;
   localparam logic [1:0] KIND_IN  = 2'h3;
   // Register map
   localparam logic [1:0] FLD_CFG = 2'h0;
   localparam logic [1:0] FLD_SP  = 2'h1;
   localparam logic [1:0] FLD_HYS = 2'h2;
   localparam logic [1:0] FLD_DLY = 2'h3;
   localparam logic [ADDR_W-1:0] ADDR_VARIANT = 10'h100;
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = 10'h104;
   localparam logic [ADDR_W-1:0] ADDR_DIRECT  = 10'h108;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_POL_BIT  = 8;
   localparam int CFG_IH_LSB   = 12;
   localparam int CFG_CHAN_BIT = 16;
   localparam int SP_LO_LSB    = 16;
   localparam int VAR_TWO_LOOP = 0;
   localparam int VAR_COMM     = 1;
   localparam int VAR_FEEDBACK = 2;
   localparam int VAR_SERVO    = 3;
   // Reset values and delay limit
   localparam logic [15:0] SP_INIT      = 16'h0000;
   localparam logic [15:0] HYS_INIT     = 16'h0014;
   localparam logic [13:0] DLY_INIT     = 14'h0000;
   localparam logic [13:0] DLY_MAX      = 14'h270f;
   localparam logic [3:0]  VARIANT_INIT = 4'h0;
   // Timebase
   localparam int CLK_HZ      = 40_000_000;
   localparam int SECOND_S    = 1;
   localparam int TICK_CYCLES = CLK_HZ * SECOND_S;

   typedef struct packed {
      logic       chan;
      logic [1:0] ih;
      logic       pol;
      logic [4:0] mode;
   } out_cfg_t;

   typedef struct packed {
      logic signed [15:0] pv;
      logic signed [15:0] sv;
      logic               scale_over;
   } loop_meas_t;

   typedef struct packed {
      logic reset_state;
      logic program_mode;
      logic fix_mode;
      logic tuning;
      logic manual;
      logic hold;
      logic guarantee;
      logic step_adv;
      logic pattern_end;
   } ctrl_state_t;

   typedef struct packed {
      logic [7:0]         time_signals;
      logic               heater_break;
      logic               heater_loop;
      logic               pot_error;
      logic signed [15:0] position;
      logic [15:0]        logic_result;
   } aux_t;
endpackage
`default_nettype wire

// File: core/limit_alarm.sv
// Limit comparator with release hysteresis
`default_nettype none
module limit_alarm
(
   input  wire logic               clk_sys_in,
   input  wire logic               nrst_in,
   input  wire logic               enable_in,
   input  wire logic [1:0]         kind_in,
   input  wire logic signed [17:0] value_in,
   input  wire logic signed [17:0] hi_in,
   input  wire logic signed [17:0] lo_in,
   input  wire logic signed [17:0] hys_in,
   output logic                    active_out
);
   logic next_active;
   logic hi_on;
   logic hi_off;
   logic lo_on;
   logic lo_off;
   logic in_on;
   logic in_off;

   always_comb
   begin
      hi_on  = value_in >= hi_in;
      hi_off = value_in < hi_in - hys_in;
      lo_on  = value_in <= lo_in;
      lo_off = value_in > lo_in + hys_in;
      in_on  = (value_in <= hi_in) && (value_in >= lo_in);
      in_off = (value_in > hi_in + hys_in) || (value_in < lo_in - hys_in);
      unique case (kind_in)
         evo_pkg::KIND_HI:  next_active = active_out ? !hi_off : hi_on;
         evo_pkg::KIND_LO:  next_active = active_out ? !lo_off : lo_on;
         evo_pkg::KIND_OUT: next_active = active_out ? !(hi_off && lo_off)
                                                     : (hi_on || lo_on);
         evo_pkg::KIND_IN:  next_active = active_out ? !in_off : in_on;
      endcase
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in || !enable_in)
         active_out <= 1'b0;
      else
         active_out <= next_active;
   end
endmodule // limit_alarm
`default_nettype wire

// File: core/delay_timer.sv
// Activation delay counted in whole seconds
`default_nettype none
module delay_timer
(
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   input  wire logic        tick_in,
   input  wire logic        source_in,
   input  wire logic [13:0] delay_in,
   output logic             fire_out
);
   logic [13:0] elapsed;

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in || !source_in)
         elapsed <= 14'h0000;
      else if (tick_in && elapsed != evo_pkg::DLY_MAX)
         elapsed <= elapsed + 14'h0001;
   end

   // Compares against time already elapsed, so a new setting takes effect
   always_comb
   begin
      fire_out = source_in &&
                 (delay_in == 14'h0000 || elapsed >= delay_in);
   end
endmodule // delay_timer
`default_nettype wire

// File: core/event_output_action_unit.sv
// Event and digital output action unit
`default_nettype none
module event_output_action_unit
#(
   parameter int TICK_CYCLES = evo_pkg::TICK_CYCLES
)
(
   input  wire logic                       clk_sys_in,
   input  wire logic                       nrst_in,
   input  wire logic [evo_pkg::ADDR_W-1:0] addr_in,
   input  wire logic [evo_pkg::DATA_W-1:0] wdata_in,
   input  wire logic                       wr_in,
   input  wire logic                       rd_in,
   input  wire evo_pkg::loop_meas_t        loop_one_in,
   input  wire evo_pkg::loop_meas_t        loop_two_in,
   input  wire evo_pkg::ctrl_state_t       state_in,
   input  wire evo_pkg::aux_t              aux_in,
   output logic [evo_pkg::DATA_W-1:0]      rdata_out,
   output logic [evo_pkg::NUM_OUT-1:0]     drive_out
);
   localparam int N = evo_pkg::NUM_OUT;

   evo_pkg::out_cfg_t  cfg      [N];
   evo_pkg::out_cfg_t  next_cfg [N];
   logic [15:0]        sp_hi    [N];
   logic [15:0]        sp_lo    [N];
   logic [15:0]        hys      [N];
   logic [13:0]        dly      [N];
   logic [N-1:0]       mode_changed;
   logic [N-1:0]       act;
   logic [N-1:0]       armed;
   logic [N-1:0]       direct;
   logic [3:0]         variant;
   logic [31:0]        tick_cnt;
   logic               tick;
   logic [31:0]        step_left;
   logic [31:0]        end_left;
   logic               booted;
   logic               prev_reset;
   logic signed [15:0] prev_sv_one;
   logic signed [15:0] prev_sv_two;
   logic               run_start;
   logic               sv_chg_one;
   logic               sv_chg_two;
   logic [1:0]         fld_sel;
   logic               per_out;

   function automatic logic mode_allowed(input int idx, input logic [4:0] m,
                                         input logic [3:0] v);
      logic ok;
      ok = (m >= evo_pkg::MODE_NONE) && (m <= evo_pkg::MODE_POT_ERR);
      if (m == evo_pkg::MODE_LOGIC && idx >= 8)
         ok = v[evo_pkg::VAR_COMM];
      if (v[evo_pkg::VAR_SERVO] && m >= evo_pkg::MODE_POS_HI)
         ok = ok && v[evo_pkg::VAR_FEEDBACK];
      if (!v[evo_pkg::VAR_SERVO] && m == evo_pkg::MODE_POT_ERR)
         ok = 1'b0;
      return ok;
   endfunction

   function automatic logic is_limit(input logic [4:0] m);
      return (m >= evo_pkg::MODE_HIGH_DEVIATION_ALARM) && (m <= evo_pkg::MODE_PV_LO);
   endfunction

   function automatic logic is_pos(input logic [4:0] m, input logic servo);
      return servo && (m == evo_pkg::MODE_POS_HI || m == evo_pkg::MODE_POS_LO);
   endfunction

   always_comb
   begin
      per_out = (addr_in[9:8] == 2'h0);
      fld_sel = addr_in[3:2];
   end

   // Configuration words, per output
   generate
      for (genvar i = 0; i < N; i++)
      begin : g_cfg
         always_comb
         begin
            next_cfg[i] = cfg[i];
            mode_changed[i] = 1'b0;
            if (wr_in && per_out && addr_in[7:4] == 4'(i) &&
                fld_sel == evo_pkg::FLD_CFG)
            begin
               next_cfg[i].pol = wdata_in[evo_pkg::CFG_POL_BIT];
               next_cfg[i].ih  = wdata_in[evo_pkg::CFG_IH_LSB +: 2];
               next_cfg[i].chan = (i < evo_pkg::NUM_EV) &&
                  variant[evo_pkg::VAR_TWO_LOOP] &&
                  wdata_in[evo_pkg::CFG_CHAN_BIT];
               if (mode_allowed(i, wdata_in[evo_pkg::CFG_MODE_LSB +: 5],
                                variant))
                  next_cfg[i].mode = wdata_in[evo_pkg::CFG_MODE_LSB +: 5];
            end
            if (!variant[evo_pkg::VAR_TWO_LOOP])
               next_cfg[i].chan = 1'b0;
            if (variant[evo_pkg::VAR_SERVO] &&
                !variant[evo_pkg::VAR_FEEDBACK] &&
                next_cfg[i].mode >= evo_pkg::MODE_POS_HI)
               next_cfg[i].mode = evo_pkg::MODE_NONE;
            mode_changed[i] = next_cfg[i].mode != cfg[i].mode;
         end

         always_ff @(posedge clk_sys_in)
         begin
            if (!nrst_in)
            begin
               cfg[i].chan <= 1'b0;
               cfg[i].ih   <= evo_pkg::IH_OFF;
               cfg[i].pol  <= 1'b0;
               cfg[i].mode <= (i == 0) ? evo_pkg::MODE_HIGH_DEVIATION_ALARM :
                              (i == 1) ? evo_pkg::MODE_DEV_LO :
                              (i == 2) ? evo_pkg::MODE_RUN :
                              evo_pkg::MODE_NONE;
            end
            else
               cfg[i] <= next_cfg[i];
         end

         always_ff @(posedge clk_sys_in)
         begin
            if (!nrst_in || mode_changed[i])
            begin
               sp_hi[i] <= evo_pkg::SP_INIT;
               sp_lo[i] <= evo_pkg::SP_INIT;
               hys[i]   <= evo_pkg::HYS_INIT;
            end
            else if (wr_in && per_out && addr_in[7:4] == 4'(i))
            begin
               if (fld_sel == evo_pkg::FLD_SP)
               begin
                  sp_hi[i] <= wdata_in[15:0];
                  sp_lo[i] <= wdata_in[evo_pkg::SP_LO_LSB +: 16];
               end
               if (fld_sel == evo_pkg::FLD_HYS)
                  hys[i] <= wdata_in[15:0];
            end
         end

         always_ff @(posedge clk_sys_in)
         begin
            if (!nrst_in)
               dly[i] <= evo_pkg::DLY_INIT;
            else if (wr_in && per_out && addr_in[7:4] == 4'(i) &&
                     fld_sel == evo_pkg::FLD_DLY &&
                     wdata_in <= 32'(evo_pkg::DLY_MAX))
               dly[i] <= wdata_in[13:0];
         end
      end
   endgenerate

   // Variant and direct output registers
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         variant <= evo_pkg::VARIANT_INIT;
         direct  <= '0;
      end
      else if (wr_in && addr_in == evo_pkg::ADDR_VARIANT)
         variant <= wdata_in[3:0];
      else if (wr_in && addr_in == evo_pkg::ADDR_DIRECT)
         direct <= wdata_in[N-1:0];
   end

   // One-second timebase
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in || tick)
         tick_cnt <= 32'h0;
      else
         tick_cnt <= tick_cnt + 32'h1;
   end

   always_comb
   begin
      tick = tick_cnt == 32'(TICK_CYCLES - 1);
   end

   // Step and end pulses last one second
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         step_left <= 32'h0;
      else if (state_in.step_adv && state_in.program_mode)
         step_left <= 32'(TICK_CYCLES);
      else if (step_left != 32'h0)
         step_left <= step_left - 32'h1;
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
         end_left <= 32'h0;
      else if (state_in.pattern_end && state_in.program_mode)
         end_left <= 32'(TICK_CYCLES);
      else if (end_left != 32'h0)
         end_left <= end_left - 32'h1;
   end

   // Inhibit arming events
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in)
      begin
         booted      <= 1'b0;
         prev_reset  <= 1'b1;
         prev_sv_one <= 16'sh0000;
         prev_sv_two <= 16'sh0000;
      end
      else
      begin
         booted      <= 1'b1;
         prev_reset  <= state_in.reset_state;
         prev_sv_one <= loop_one_in.sv;
         prev_sv_two <= loop_two_in.sv;
      end
   end

   always_comb
   begin
      run_start  = prev_reset && !state_in.reset_state;
      sv_chg_one = booted && (prev_sv_one != loop_one_in.sv);
      sv_chg_two = booted && (prev_sv_two != loop_two_in.sv);
   end

   generate
      for (genvar i = 0; i < N; i++)
      begin : g_out
         evo_pkg::loop_meas_t meas;
         logic signed [17:0]  value;
         logic [1:0]          kind;
         logic                en;
         logic                raw;
         logic                src;
         logic                fired;
         logic                arm;
         logic [4:0]          m;

         always_comb
         begin
            m = cfg[i].mode;
            meas = cfg[i].chan ? loop_two_in : loop_one_in;
            if (is_pos(m, variant[evo_pkg::VAR_SERVO]))
               value = 18'(aux_in.position);
            else if (m >= evo_pkg::MODE_MEASURED_HIGH_ABSOLUTE)
               value = 18'(meas.pv);
            else
               value = 18'(meas.pv) - 18'(meas.sv);
            unique case (m)
               evo_pkg::MODE_HIGH_DEVIATION_ALARM, evo_pkg::MODE_MEASURED_HIGH_ABSOLUTE,
               evo_pkg::MODE_POS_HI:  kind = evo_pkg::KIND_HI;
               evo_pkg::MODE_OUTSIDE_BAND_ALARM: kind = evo_pkg::KIND_OUT;
               evo_pkg::MODE_INSIDE_BAND_ALARM:  kind = evo_pkg::KIND_IN;
               default:               kind = evo_pkg::KIND_LO;
            endcase
            en = (is_limit(m) || is_pos(m, variant[evo_pkg::VAR_SERVO])) &&
                 !state_in.reset_state;
            arm = ((cfg[i].ih == evo_pkg::IH_POWER ||
                    cfg[i].ih == evo_pkg::IH_SV) &&
                   (!booted || run_start)) ||
                  (cfg[i].ih == evo_pkg::IH_SV &&
                   (cfg[i].chan ? sv_chg_two : sv_chg_one));
            if (is_limit(m) && meas.scale_over)
               src = cfg[i].ih != evo_pkg::IH_NONE;
            else
               src = raw && !armed[i];
         end

         limit_alarm u_alarm
         (
            .clk_sys_in (clk_sys_in),
            .nrst_in    (nrst_in),
            .enable_in  (en),
            .kind_in    (kind),
            .value_in   (value),
            .hi_in      (18'(signed'(sp_hi[i]))),
            .lo_in      (18'(signed'(sp_lo[i]))),
            .hys_in     (18'(signed'(hys[i]))),
            .active_out (raw)
         );

         delay_timer u_delay
         (
            .clk_sys_in (clk_sys_in),
            .nrst_in    (nrst_in),
            .tick_in    (tick),
            .source_in  (src && is_limit(m)),
            .delay_in   (dly[i]),
            .fire_out   (fired)
         );

         // Arming wins over the release in the same cycle
         always_ff @(posedge clk_sys_in)
         begin
            if (!nrst_in)
               armed[i] <= 1'b0;
            else if (arm)
               armed[i] <= 1'b1;
            else if (!raw)
               armed[i] <= 1'b0;
         end

         always_comb
         begin
            act[i] = 1'b0;
            if (is_limit(m))
               act[i] = fired;
            else if (is_pos(m, variant[evo_pkg::VAR_SERVO]))
               act[i] = src;
            else if (m >= evo_pkg::MODE_TS_FIRST &&
                     m <= evo_pkg::MODE_TS_LAST)
               act[i] = state_in.program_mode &&
                        aux_in.time_signals[3'(m - evo_pkg::MODE_TS_FIRST)];
            else
               unique case (m)
                  evo_pkg::MODE_SCALE:    act[i] = meas.scale_over;
                  evo_pkg::MODE_FIX:      act[i] = state_in.fix_mode;
                  evo_pkg::MODE_TUNE:     act[i] = state_in.tuning;
                  evo_pkg::MODE_MANUAL:   act[i] = state_in.manual;
                  evo_pkg::MODE_RUN:      act[i] = !state_in.reset_state;
                  evo_pkg::MODE_HOLD:     act[i] = state_in.hold &&
                                                   state_in.program_mode;
                  evo_pkg::MODE_SOAK:     act[i] = state_in.guarantee &&
                                                   state_in.program_mode;
                  evo_pkg::MODE_STEP:     act[i] = |step_left;
                  evo_pkg::MODE_END:      act[i] = end_left != 32'h0;
                  evo_pkg::MODE_LOGIC:    act[i] = (i >= 8) ? direct[i]
                                                   : aux_in.logic_result[i];
                  evo_pkg::MODE_HEAT_BRK: act[i] = aux_in.heater_break;
                  evo_pkg::MODE_HEAT_LP:  act[i] = aux_in.heater_loop;
                  evo_pkg::MODE_POT_ERR:  act[i] = aux_in.pot_error;
                  default:                act[i] = 1'b0;
               endcase
         end

         always_ff @(posedge clk_sys_in)
         begin
            if (!nrst_in)
               drive_out[i] <= 1'b0;
            else
               drive_out[i] <= act[i] ^ cfg[i].pol;
         end
      end
   endgenerate

   // Register read port, data one cycle after the strobe
   always_ff @(posedge clk_sys_in)
   begin
      if (!nrst_in || !rd_in)
         rdata_out <= '0;
      else if (per_out)
         unique case (fld_sel)
            evo_pkg::FLD_CFG: rdata_out <=
               32'({cfg[addr_in[7:4]].chan, 2'h0, cfg[addr_in[7:4]].ih,
                    3'h0, cfg[addr_in[7:4]].pol, 3'h0,
                    cfg[addr_in[7:4]].mode});
            evo_pkg::FLD_SP:  rdata_out <= {sp_lo[addr_in[7:4]],
                                            sp_hi[addr_in[7:4]]};
            evo_pkg::FLD_HYS: rdata_out <= 32'(hys[addr_in[7:4]]);
            evo_pkg::FLD_DLY: rdata_out <= 32'(dly[addr_in[7:4]]);
         endcase
      else if (addr_in == evo_pkg::ADDR_VARIANT)
         rdata_out <= 32'(variant);
      else if (addr_in == evo_pkg::ADDR_STATUS)
         rdata_out <= 32'(act);
      else if (addr_in == evo_pkg::ADDR_DIRECT)
         rdata_out <= 32'(direct);
      else
         rdata_out <= '0;
   end
endmodule // event_output_action_unit
`default_nettype wire

// File: sim/evo_process_model.sv
// Program sequencer model that feeds the controller state
`default_nettype none
module evo_process_model
(
   input  wire logic                clk_sys_in,
   input  wire logic                nrst_in,
   input  wire logic                run_in,
   input  wire logic                adv_in,
   input  wire logic                end_in,
   output var evo_pkg::ctrl_state_t state_out
);
   always_ff @(posedge clk_sys_in)
   begin
      state_out              <= '0;
      state_out.reset_state  <= !(nrst_in && run_in);
      state_out.program_mode <= nrst_in;
      state_out.step_adv     <= nrst_in && adv_in;
      state_out.pattern_end  <= nrst_in && end_in;
   end
endmodule // evo_process_model
`default_nettype wire

// File: sim/evo_assertions.sv
// Port checker of the event output action unit
`default_nettype none
module evo_assertions
(
   input wire logic                         clk_sys_in,
   input wire logic                         nrst_in,
   input wire logic [evo_pkg::ADDR_W-1:0]   addr_in,
   input wire logic [evo_pkg::DATA_W-1:0]   wdata_in,
   input wire logic                         wr_in,
   input wire logic                         rd_in,
   input wire evo_pkg::loop_meas_t          loop_one_in,
   input wire evo_pkg::loop_meas_t          loop_two_in,
   input wire evo_pkg::ctrl_state_t         state_in,
   input wire evo_pkg::aux_t                aux_in,
   input wire logic [evo_pkg::DATA_W-1:0]   rdata_out,
   input wire logic [evo_pkg::NUM_OUT-1:0]  drive_out
);
   logic               wrote;
   logic [1:0]         cnt;
   logic signed [17:0] dev;
   logic               tch;
   logic               rs;
   logic               so;
   logic               go;
   assign dev = $signed(loop_one_in.pv) - $signed(loop_one_in.sv);
   assign tch = wrote | wr_in;
   assign rs  = state_in.reset_state;
   assign so  = loop_one_in.scale_over;
   assign go  = !rs && !tch;
   always_ff @(posedge clk_sys_in)
   begin
      wrote <= nrst_in & tch;
      cnt   <= !nrst_in ? 2'h0 : (cnt == 2'h3) ? cnt : cnt + 2'h1;
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   AST_QUIET: assert property ($past(!nrst_in) |-> drive_out == '0)
      else $error("outputs active after reset");
   AST_DO_IDLE: assert property (!tch |-> drive_out[15:3] == '0)
      else $error("digital output active at default");
   AST_RUN: assert property (!tch && cnt == 2'h3 |->
      drive_out[2] == !$past(rs)) else $error("run status wrong");
   AST_RST_OFF: assert property ((rs && !so && !tch)[*2] |->
      ##1 drive_out[1:0] == '0) else $error("alarm active in reset");
   AST_HI_SET: assert property (go && dev >= 0 ##1 go |=> drive_out[0])
      else $error("high alarm not set");
   AST_HI_CLR: assert property (go && !so && dev < -20 ##1 go && !so
      |=> !drive_out[0]) else $error("high alarm not released");
   AST_LO_SET: assert property (go && dev <= 0 ##1 go |=> drive_out[1])
      else $error("low alarm not set");
   AST_SO: assert property ((!tch && so)[*2] |=> drive_out[1:0] == 2'h3)
      else $error("scale over not shown");
   cover property (go && dev < -20 ##2 !drive_out[0]);
   cover property (so ##2 drive_out[1]);
   cover property (rs ##2 !drive_out[2]);
endmodule // evo_assertions
bind event_output_action_unit evo_assertions i_chk
(
   .clk_sys_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
   .loop_one_in, .loop_two_in, .state_in, .aux_in, .rdata_out, .drive_out
);
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench of the event output action unit
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 20;
   logic                        clk_sys_in = 1'b0, nrst_in = 1'b0;
   logic                        wr_in = 1'b0, rd_in = 1'b0, rd_prev = 1'b0;
   logic                        run = 1'b0, adv = 1'b0, endp = 1'b0;
   logic                        hi = 1'b1, lo = 1'b1;
   logic [evo_pkg::ADDR_W-1:0]  addr_in = '0;
   logic [31:0]                 wdata_in = '0, rdata, r, e, rq[$], dq[$];
   logic [evo_pkg::NUM_OUT-1:0] drive;
   evo_pkg::loop_meas_t         l_one = '0, l_two = '0;
   evo_pkg::aux_t               aux = '0;
   evo_pkg::ctrl_state_t        state;
   int                          error_cnt = 0, n_compared = 0, pv;
   int                          seed = 32'h8186a8b7;
   logic [9:0]  t_a[6] = '{10'h0, 10'h30, 10'h60, 10'h80, 10'ha0, 10'hd0};
   logic [31:0] t_w[6] = '{32'h13004, 32'hc, 32'hc, 32'hc, 32'h1c, 32'h12};
   logic [31:0] t_e[6] = '{32'h3004, 32'hc, 32'hc, 32'h1, 32'h1, 32'h12};
   always #12.5 clk_sys_in = ~clk_sys_in;
   event_output_action_unit #(.TICK_CYCLES(TICK)) i_dut
   (
      .clk_sys_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
      .loop_one_in (l_one), .loop_two_in (l_two), .state_in (state),
      .aux_in (aux), .rdata_out (rdata), .drive_out (drive)
   );
   evo_process_model i_proc
   (
      .clk_sys_in, .nrst_in, .run_in (run), .adv_in (adv),
      .end_in (endp), .state_out (state)
   );
   task automatic bus(logic w, logic [9:0] a, logic [31:0] d);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= w;
      rd_in    <= !w;
      if (!w) rq.push_back(d);
      @(posedge clk_sys_in);
      wr_in    <= 1'b0;
      rd_in    <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic ex(int n, logic [15:0] m, logic [15:0] v);
      repeat (n) @(posedge clk_sys_in);
      dq.push_back({m, v});
   endtask
   task automatic chk_rd(logic [31:0] x);
      n_compared++;
      error_cnt += (rdata !== x);
      if (rdata !== x) $display("FAIL rdata expected %h seen %h", x, rdata);
   endtask
   task automatic chk_drv(logic [31:0] x);
      n_compared++;
      error_cnt += ((drive & x[31:16]) !== x[15:0]);
      if ((drive & x[31:16]) !== x[15:0])
         $display("FAIL drive expected %h seen %h", x[15:0], drive);
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clk_sys_in) rd_prev <= rd_in;
   always @(negedge clk_sys_in)
   begin
      if (rd_prev === 1'b1) chk_rd(rq.pop_front());
      if (dq.size() > 0) chk_drv(dq.pop_front());
   end
   initial
   begin
      #100us;
      error_cnt++;
      final_report();
   end
   initial
   begin
      repeat (6) @(posedge clk_sys_in);
      nrst_in <= 1'b1;
      run     <= 1'b1;
      ex(4, 16'hffff, 16'h0007);
      bus(1'b0, 10'h20, 32'hd);
      run <= 1'b0;
      ex(4, 16'h0007, 16'h0000);
      l_one.scale_over <= 1'b1;
      ex(3, 16'h0003, 16'h0003);
      l_one.scale_over <= 1'b0;
      run <= 1'b1;
      ex(4, 16'h0007, 16'h0007);
      repeat (24)
      begin
         pv = $random(seed) % 61;
         l_one.pv <= pv[15:0];
         hi = (pv >= 0) | (hi & (pv >= -20));
         lo = (pv <= 0) | (lo & (pv <= 20));
         ex(3, 16'h0003, {14'h0, lo, hi});
      end
      l_one.scale_over <= 1'b1;
      bus(1'b1, 10'h0, 32'h3002);
      ex(2, 16'h0001, 16'h0000);
      l_one.scale_over <= 1'b0;
      bus(1'b1, 10'h4, 32'h50010);
      bus(1'b0, 10'h4, 32'h50010);
      bus(1'b1, 10'h0, 32'h3004);
      bus(1'b0, 10'h4, 32'h0);
      bus(1'b0, 10'h8, 32'h14);
      foreach (t_a[i])
      begin
         bus(1'b1, t_a[i], t_w[i]);
         bus(1'b0, t_a[i], t_e[i]);
      end
      bus(1'b1, 10'hf0, 32'h101);
      repeat (6)
      begin
         r = $random(seed);
         aux.time_signals <= r[7:0];
         aux.logic_result <= r[23:8];
         e = {16'h0, 2'b10, r[0], 6'h0, r[14], 2'h0, r[11], 3'h0};
         ex(3, 16'ha048, e[15:0]);
      end
      bus(1'b1, 10'h40, 32'h10);
      bus(1'b1, 10'h50, 32'h11);
      for (int k = 0; k < 2; k++)
      begin
         adv  <= (k == 0);
         endp <= (k == 1);
         @(posedge clk_sys_in);
         adv  <= 1'b0;
         endp <= 1'b0;
         ex(3, 16'h0030, 16'h0010 << k);
         ex(TICK - 2, 16'h0030, 16'h0010 << k);
         ex(1, 16'h0030, 16'h0000);
      end
      l_one.pv <= 16'h0064;
      bus(1'b1, 10'h1c, 32'h2);
      bus(1'b1, 10'h1c, 32'h2710);
      bus(1'b0, 10'h1c, 32'h2);
      l_one.pv <= 16'hfffb;
      ex(TICK - 2, 16'h0002, 16'h0000);
      ex(2 * TICK + 4, 16'h0002, 16'h0002);
      bus(1'b1, 10'h10, 32'h2003);
      l_one.sv <= 16'h0001;
      ex(3, 16'h0002, 16'h0000);
      l_one.pv <= 16'h0064;
      ex(3, 16'h0002, 16'h0000);
      l_one.pv <= 16'hfffb;
      ex(2 * TICK + 4, 16'h0002, 16'h0002);
      bus(1'b0, 10'h200, 32'h0);
      final_report();
   end
endmodule // tb_top
`default_nettype wire
